// [rtl/alu_exec_core.sv]
// Instruction execution datapath with data memory, table memory and APB slave
//
// Notes on behaviour
// - Subtracts clear carry on negative result, set it on positive or zero.
// - Memory subtract stores accumulator minus byte into byte; six flags update.
// - Immediate subtract leaves accumulator minus immediate in accumulator; six flags.
// - Nibble exchange swaps byte halves in memory; flags untouched.
// - Nibble exchange to accumulator leaves memory as is; flags untouched.
// - Zero skip writes byte back, skips next when byte is zero.
// - Copy skip loads byte into accumulator, skips when it is zero.
// - Bit skip skips next when selected bit is zero; flags untouched.
// - Every skip instruction occupies two instruction cycles via a dummy cycle.
// - Page table read uses high and low pointers; low to memory, high latched.
// - Last-page table read uses low pointer on the final page.
// - Incrementing page read bumps low pointer then reads with new pointer.
// - Incrementing last-page read bumps low pointer then reads last page.
// - Exclusive-or forms write accumulator or memory; only zero flag updates.
// - Far forms reach every data memory byte directly.
// - Add with carry sums accumulator, byte and carry; five flags update.
// - Plain add sums accumulator and byte; five flags update.
// - AND forms write accumulator or memory; only zero flag updates.
// - Clear writes zero to byte, bit form clears one bit; no flags.
// - Invert complements byte into memory or accumulator; zero flag updates.
// - Decimal adjust adds six per large or carried nibble into memory; only carry.
// - Increment and decrement write memory or accumulator; only zero flag.
module alu_exec_core
   import alu_exec_pkg::*;
#(
   parameter int unsigned DMEM_W = alu_exec_pkg::DMEM_AW, // Data memory address width
   parameter int unsigned PMEM_W = alu_exec_pkg::PMEM_AW  // Program memory address width
) (
   input  wire logic                              clk,     // 40 MHz system clock
   input  wire logic                              nrst,    // Asynchronous reset, active low
   input  wire logic                              psel,    // APB select
   input  wire logic                              penable, // APB access phase
   input  wire logic                              pwrite,  // APB direction, high for write
   input  wire logic [alu_exec_pkg::APB_AW-1:0]   paddr,   // APB byte address
   input  wire logic [31:0]                       pwdata,  // APB write data
   output logic      [31:0]                       prdata,  // APB read data
   output logic                                   pready,  // APB ready
   output logic                                   pslverr, // APB error
   output logic                                   skip_o   // Last instruction skipped next
);
   import alu_exec_pkg::*;

   localparam int unsigned HP_W = PMEM_W - DATA_W;

   logic                 rst_meta_q;
   logic                 rst_n_q;
   state_e               state_q;
   state_e               state_d;
   op_e                  cmd_q;
   logic [2:0]           bit_q;
   logic [5:0]           flags_q;
   logic [5:0]           flags_d;
   logic [DATA_W-1:0]    acc_q;
   logic [DATA_W-1:0]    imm_q;
   logic [DMEM_W-1:0]    maddr_q;
   logic [DATA_W-1:0]    table_pointer_low_q;
   logic [DATA_W-1:0]    table_pointer_low_d;
   logic [HP_W-1:0]      table_pointer_high_q;
   logic [DATA_W-1:0]    table_word_high_latch_q;
   logic [PMEM_W-1:0]    paddr_q;
   logic [DATA_W-1:0]    dmem_q [2**DMEM_W];
   logic [WORD_W-1:0]    pmem_q [2**PMEM_W];
   logic [31:0]          prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic                 skip_q;
   logic                 skip_d;
   logic                 acc_we;
   logic                 mem_we;
   logic                 tbl_we;
   logic                 skip_op;
   logic [DATA_W-1:0]    mem_b;
   logic [DATA_W-1:0]    res;
   logic [10:0]          sum;
   logic [PMEM_W-1:0]    prog_a;
   logic [WORD_W-1:0]    word;
   logic [7:0]           adj;
   logic                 busy;
   logic                 exec;
   logic                 setup;
   logic                 wr_ok;
   logic                 mapped;

   // Returns {ov, ac, c, sum[7:0]}; subtract feeds the inverted operand with carry-in 1
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [4:0] lo;
      logic [8:0] full;
      logic       ov;
      lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      ov   = (a[7] == b[7]) && (full[7] != a[7]);
      return {ov, lo[4], full[8], full[7:0]};
   endfunction : add8

   // Applies arithmetic flags; chained zero only for the subtract forms
   function automatic logic [5:0] arith_flags(input logic [10:0] s, input logic [5:0] f, input logic upd_cz);
      logic [5:0] r;
      r       = f;
      r[F_OV] = s[10];
      r[F_AC] = s[9];
      r[F_C]  = s[8];
      r[F_Z]  = (s[7:0] == 8'h00);
      r[F_SC] = s[10] ^ s[7];
      if (upd_cz) begin
         r[F_CZ] = (s[7:0] == 8'h00);
      end
      return r;
   endfunction : arith_flags

   function automatic logic [5:0] zero_flag(input logic [7:0] v, input logic [5:0] f);
      logic [5:0] r;
      r      = f;
      r[F_Z] = (v == 8'h00);
      return r;
   endfunction : zero_flag

   // Reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   assign busy   = (state_q != ST_IDLE);
   assign exec   = (state_q == ST_EXEC);
   assign setup  = psel && !penable;
   assign wr_ok  = psel && penable && pready_q && pwrite && !pslverr_q;
   assign mem_b  = dmem_q[maddr_q];
   // Registers fill every aligned word up to the program data port
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_PDATA);

   // Execution datapath
   always_comb begin
      res     = BYTE_RST;
      sum     = '0;
      adj     = 8'h00;
      acc_we  = 1'b0;
      mem_we  = 1'b0;
      tbl_we  = 1'b0;
      skip_op = 1'b0;
      skip_d  = 1'b0;
      flags_d = flags_q;
      table_pointer_low_d  = table_pointer_low_q;
      prog_a  = {table_pointer_high_q, table_pointer_low_q};
      word    = pmem_q[prog_a];
      case (cmd_q)
         OP_MINUS_TO_MEM, OP_MINUS_IMM: begin
            mem_we  = (cmd_q == OP_MINUS_TO_MEM);
            acc_we  = !mem_we;
            sum     = add8(acc_q, ~(mem_we ? mem_b : imm_q), 1'b1);
            res     = sum[7:0];
            flags_d = arith_flags(sum, flags_q, 1'b1);
         end
         OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_ACC: begin
            res    = {mem_b[3:0], mem_b[7:4]};
            mem_we = (cmd_q == OP_NIBBLE_EXCHANGE);
            acc_we = !mem_we;
         end
         OP_SKIP_WHEN_ZERO_MEM, OP_SKIP_ZERO_COPY_ACC: begin
            res     = mem_b;
            mem_we  = (cmd_q == OP_SKIP_WHEN_ZERO_MEM);
            acc_we  = !mem_we;
            skip_op = 1'b1;
            skip_d  = (mem_b == 8'h00);
         end
         OP_SKIP_BIT_ZERO: begin
            skip_op = 1'b1;
            skip_d  = !mem_b[bit_q];
         end
         OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST_PAGE, OP_PTR_INC_TABLE_READ, OP_PTR_INC_TABLE_LAST: begin
            if (cmd_q == OP_PTR_INC_TABLE_READ || cmd_q == OP_PTR_INC_TABLE_LAST) begin
               table_pointer_low_d = table_pointer_low_q + 8'h01;
            end
            if (cmd_q == OP_TABLE_READ_LAST_PAGE || cmd_q == OP_PTR_INC_TABLE_LAST) begin
               prog_a = {{HP_W{1'b1}}, table_pointer_low_d};
            end else begin
               prog_a = {table_pointer_high_q, table_pointer_low_d};
            end
            word   = pmem_q[prog_a];
            res    = word[7:0];
            mem_we = 1'b1;
            tbl_we = 1'b1;
         end
         OP_EXCLUSIVE_OR_ACC, OP_EXCLUSIVE_OR_MEM, OP_EXCLUSIVE_OR_IMM: begin
            res     = acc_q ^ ((cmd_q == OP_EXCLUSIVE_OR_IMM) ? imm_q : mem_b);
            mem_we  = (cmd_q == OP_EXCLUSIVE_OR_MEM);
            acc_we  = !mem_we;
            flags_d = zero_flag(res, flags_q);
         end
         OP_FAR_ADD_CARRY_ACC, OP_FAR_ADD_CARRY_MEM, OP_FAR_ADD_ACC, OP_FAR_ADD_MEM: begin
            sum     = add8(acc_q, mem_b, flags_q[F_C] && (cmd_q == OP_FAR_ADD_CARRY_ACC ||
                                                          cmd_q == OP_FAR_ADD_CARRY_MEM));
            res     = sum[7:0];
            mem_we  = (cmd_q == OP_FAR_ADD_CARRY_MEM) || (cmd_q == OP_FAR_ADD_MEM);
            acc_we  = !mem_we;
            flags_d = arith_flags(sum, flags_q, 1'b0);
         end
         OP_FAR_AND_TO_ACC, OP_FAR_AND_TO_MEM: begin
            res     = acc_q & mem_b;
            mem_we  = (cmd_q == OP_FAR_AND_TO_MEM);
            acc_we  = !mem_we;
            flags_d = zero_flag(res, flags_q);
         end
         OP_FAR_CLEAR, OP_FAR_CLEAR_BIT: begin
            res    = (cmd_q == OP_FAR_CLEAR) ? 8'h00 : (mem_b & ~(8'h01 << bit_q));
            mem_we = 1'b1;
         end
         OP_FAR_INVERT, OP_FAR_INVERT_TO_ACC: begin
            res     = ~mem_b;
            mem_we  = (cmd_q == OP_FAR_INVERT);
            acc_we  = !mem_we;
            flags_d = zero_flag(res, flags_q);
         end
         OP_FAR_DECIMAL_ADJUST: begin
            adj[7:4]   = (flags_q[F_C] || acc_q[7:4] > BCD_LIMIT) ? BCD_ADJ : 4'h0;
            adj[3:0]   = (flags_q[F_AC] || acc_q[3:0] > BCD_LIMIT) ? BCD_ADJ : 4'h0;
            sum        = add8(acc_q, adj, 1'b0);
            res        = sum[7:0];
            mem_we     = 1'b1;
            flags_d[F_C] = flags_q[F_C] || sum[8];
         end
         OP_FAR_DECREMENT, OP_FAR_DECREMENT_TO_ACC, OP_FAR_INCREMENT, OP_FAR_INCREMENT_TO_ACC: begin
            if (cmd_q == OP_FAR_DECREMENT || cmd_q == OP_FAR_DECREMENT_TO_ACC) begin
               res = mem_b - 8'h01;
            end else begin
               res = mem_b + 8'h01;
            end
            mem_we  = (cmd_q == OP_FAR_DECREMENT) || (cmd_q == OP_FAR_INCREMENT);
            acc_we  = !mem_we;
            flags_d = zero_flag(res, flags_q);
         end
         default: res = BYTE_RST;
      endcase
   end

   // Sequencer: skips hold one dummy cycle
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:  state_d = (wr_ok && paddr == OFS_CMD) ? ST_EXEC : ST_IDLE;
         ST_EXEC:  state_d = skip_op ? ST_DUMMY : ST_IDLE;
         ST_DUMMY: state_d = ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         cmd_q   <= OP_NOP;
         bit_q   <= 3'h0;
      end else begin
         state_q <= state_d;
         if (!busy && wr_ok && paddr == OFS_CMD) begin
            cmd_q <= op_e'(pwdata[CMD_OP_LSB +: 5]);
            bit_q <= pwdata[CMD_BIT_LSB +: 3];
         end
      end
   end

   // Core registers; software writes are refused while busy, so exec has them alone
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         acc_q   <= BYTE_RST;
         flags_q <= FLAGS_RST;
         skip_q  <= 1'b0;
      end else if (exec) begin
         flags_q <= flags_d;
         skip_q  <= skip_d;
         if (acc_we) begin
            acc_q <= res;
         end
      end else if (wr_ok && paddr == OFS_ACC) begin
         acc_q <= pwdata[7:0];
      end else if (wr_ok && paddr == OFS_STATUS) begin
         flags_q <= pwdata[5:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         imm_q   <= BYTE_RST;
         maddr_q <= '0;
         table_pointer_high_q  <= '0;
         paddr_q <= '0;
      end else if (wr_ok) begin
         case (paddr)
            OFS_IMM:   imm_q   <= pwdata[7:0];
            OFS_MADDR: maddr_q <= pwdata[DMEM_W-1:0];
            OFS_TABLE_POINTER_HIGH:  table_pointer_high_q  <= pwdata[HP_W-1:0];
            OFS_PADDR: paddr_q <= pwdata[PMEM_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Table pointer and high-byte latch
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         table_pointer_low_q <= BYTE_RST;
         table_word_high_latch_q <= BYTE_RST;
      end else if (exec && tbl_we) begin
         table_pointer_low_q <= table_pointer_low_d;
         table_word_high_latch_q <= word[15:8];
      end else if (wr_ok && paddr == OFS_TABLE_POINTER_LOW) begin
         table_pointer_low_q <= pwdata[7:0];
      end
   end

   // Memories carry no reset; contents are undefined until written
   always_ff @(posedge clk) begin
      if (exec && mem_we) begin
         dmem_q[maddr_q] <= res;
      end else if (wr_ok && paddr == OFS_MDATA) begin
         dmem_q[maddr_q] <= pwdata[7:0];
      end
      if (wr_ok && paddr == OFS_PDATA) begin
         pmem_q[paddr_q] <= pwdata[WORD_W-1:0];
      end
   end

   // APB slave: answer is prepared in setup, so access completes with no wait state
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && (!mapped || (pwrite && busy));
         if (setup && !pwrite) begin
            case (paddr)
               OFS_CMD:    prdata_q <= {21'h0, bit_q, 3'h0, cmd_q};
               OFS_STATUS: prdata_q <= {22'h0, skip_q, busy, 2'h0, flags_q};
               OFS_ACC:    prdata_q <= {24'h0, acc_q};
               OFS_MADDR:  prdata_q <= 32'(maddr_q);
               OFS_MDATA:  prdata_q <= {24'h0, mem_b};
               OFS_IMM:    prdata_q <= {24'h0, imm_q};
               OFS_TABLE_POINTER_LOW:   prdata_q <= {24'h0, table_pointer_low_q};
               OFS_TABLE_POINTER_HIGH:   prdata_q <= 32'(table_pointer_high_q);
               OFS_TABLE_WORD_HIGH_LATCH:   prdata_q <= {24'h0, table_word_high_latch_q};
               OFS_PADDR:  prdata_q <= 32'(paddr_q);
               OFS_PDATA:  prdata_q <= {16'h0, pmem_q[paddr_q]};
               default:    prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign skip_o  = skip_q;

endmodule : alu_exec_core

// [rtl/alu_exec_pkg.sv]
// Constants, opcodes and register layout for the instruction execution unit
package alu_exec_pkg;

   localparam int unsigned DATA_W  = 8;
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned APB_AW  = 8;
   localparam int unsigned DMEM_AW = 8;
   localparam int unsigned PMEM_AW = 9;

   // Register byte offsets
   localparam logic [APB_AW-1:0] OFS_CMD    = 8'h00;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
   localparam logic [APB_AW-1:0] OFS_ACC    = 8'h08;
   localparam logic [APB_AW-1:0] OFS_MADDR  = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_MDATA  = 8'h10;
   localparam logic [APB_AW-1:0] OFS_IMM    = 8'h14;
   localparam logic [APB_AW-1:0] OFS_TABLE_POINTER_LOW   = 8'h18;
   localparam logic [APB_AW-1:0] OFS_TABLE_POINTER_HIGH   = 8'h1C;
   localparam logic [APB_AW-1:0] OFS_TABLE_WORD_HIGH_LATCH   = 8'h20;
   localparam logic [APB_AW-1:0] OFS_PADDR  = 8'h24;
   localparam logic [APB_AW-1:0] OFS_PDATA  = 8'h28;

   // Command register fields
   localparam int unsigned CMD_OP_LSB  = 0;
   localparam int unsigned CMD_BIT_LSB = 8;

   // Flag positions in the status register
   localparam int unsigned F_C    = 0;
   localparam int unsigned F_AC   = 1;
   localparam int unsigned F_Z    = 2;
   localparam int unsigned F_OV   = 3;
   localparam int unsigned F_SC   = 4;
   localparam int unsigned F_CZ   = 5;
   localparam int unsigned ST_BUSY_BIT = 8;
   localparam int unsigned ST_SKIP_BIT = 9;

   localparam logic [5:0]        FLAGS_RST = 6'h00;
   localparam logic [DATA_W-1:0] BYTE_RST  = 8'h00;
   localparam logic [3:0]        BCD_LIMIT = 4'h9;
   localparam logic [3:0]        BCD_ADJ   = 4'h6;

   typedef enum logic [4:0] {
      OP_NOP                  = 5'h00,
      OP_MINUS_TO_MEM         = 5'h01,
      OP_MINUS_IMM            = 5'h02,
      OP_NIBBLE_EXCHANGE      = 5'h03,
      OP_NIBBLE_EXCHANGE_ACC  = 5'h04,
      OP_SKIP_WHEN_ZERO_MEM   = 5'h05,
      OP_SKIP_ZERO_COPY_ACC   = 5'h06,
      OP_SKIP_BIT_ZERO        = 5'h07,
      OP_TABLE_READ_PAGE      = 5'h08,
      OP_TABLE_READ_LAST_PAGE = 5'h09,
      OP_PTR_INC_TABLE_READ   = 5'h0A,
      OP_PTR_INC_TABLE_LAST   = 5'h0B,
      OP_EXCLUSIVE_OR_ACC     = 5'h0C,
      OP_EXCLUSIVE_OR_MEM     = 5'h0D,
      OP_EXCLUSIVE_OR_IMM     = 5'h0E,
      OP_FAR_ADD_CARRY_ACC    = 5'h0F,
      OP_FAR_ADD_CARRY_MEM    = 5'h10,
      OP_FAR_ADD_ACC          = 5'h11,
      OP_FAR_ADD_MEM          = 5'h12,
      OP_FAR_AND_TO_ACC       = 5'h13,
      OP_FAR_AND_TO_MEM       = 5'h14,
      OP_FAR_CLEAR            = 5'h15,
      OP_FAR_CLEAR_BIT        = 5'h16,
      OP_FAR_INVERT           = 5'h17,
      OP_FAR_INVERT_TO_ACC    = 5'h18,
      OP_FAR_DECIMAL_ADJUST   = 5'h19,
      OP_FAR_DECREMENT        = 5'h1A,
      OP_FAR_DECREMENT_TO_ACC = 5'h1B,
      OP_FAR_INCREMENT        = 5'h1C,
      OP_FAR_INCREMENT_TO_ACC = 5'h1D
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_DUMMY = 2'b11
   } state_e;

endpackage : alu_exec_pkg

// [verif/alu_exec_core_monitor.sv]
// Port checker for the execution unit: APB timing, refusals and skip timing
module alu_exec_core_monitor (
   input wire logic                            clk,     // System clock
   input wire logic                            nrst,    // Reset, active low
   input wire logic                            psel,    // APB select
   input wire logic                            penable, // APB access phase
   input wire logic                            pwrite,  // APB direction
   input wire logic [alu_exec_pkg::APB_AW-1:0] paddr,   // APB address
   input wire logic [31:0]                     pwdata,  // APB write data
   input wire logic [31:0]                     prdata,  // APB read data
   input wire logic                            pready,  // APB ready
   input wire logic                            pslverr, // APB error
   input wire logic                            skip_o   // Skip decision
);
   import alu_exec_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic cmd_wr;
   logic skip_cmd;
   assign cmd_wr   = pready && pwrite && !pslverr && paddr == OFS_CMD;
   assign skip_cmd = cmd_wr && pwdata[4:0] inside {5'h05, 5'h06, 5'h07};

   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   ready_needs_setup_a: assert property (pready |-> $past(psel && !penable) && psel && penable)
      else $error("pready without setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_refused_a: assert property (pready && paddr > OFS_PDATA |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   upper_bits_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   skip_busy_refused_a: assert property (skip_cmd ##3 (pready && pwrite) |-> pslverr)
      else $error("write accepted during dummy cycle");
   plain_op_free_a: assert property (cmd_wr && !skip_cmd ##3 (pready && pwrite && paddr == OFS_IMM) |-> !pslverr)
      else $error("write refused after one cycle op");
   skip_timing_a: assert property ($changed(skip_o) |-> $past(cmd_wr, 2))
      else $error("skip flag moved without command");

   cover property ($rose(skip_o));
   cover property (pslverr);
   cover property (skip_cmd);
endmodule : alu_exec_core_monitor

bind alu_exec_core alu_exec_core_monitor alu_exec_core_monitor_inst (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .skip_o(skip_o));

// [verif/mcu_instruction_semantics_s_to_l_test.sv]
// Self-checking bench for the execution unit driven over APB
module mcu_instruction_semantics_s_to_l_test;
   timeunit 1ns;
   timeprecision 1ps;
   import alu_exec_pkg::*;
   typedef struct packed {
      op_e        op;
      logic [2:0] b;
      logic [7:0] acc;
      logic [7:0] mem;
      logic [5:0] fin;
      logic [7:0] eacc;
      logic [7:0] emem;
      logic [9:0] est;
   } vec_s;
   logic        clk     = 1'b0;
   logic        nrst    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        skip_o;
   int          fail_count  = 0;
   int          comparisons = 0;
   // Immediate forms take their operand from the mem column
   vec_s vt [29] = '{
      '{OP_MINUS_TO_MEM,3'h0,8'h10,8'h20,6'h00,8'h10,8'hF0,10'h012},
      '{OP_MINUS_IMM,3'h0,8'h80,8'h01,6'h00,8'h7F,8'h01,10'h019},
      '{OP_MINUS_IMM,3'h0,8'h33,8'h33,6'h00,8'h00,8'h33,10'h027},
      '{OP_NIBBLE_EXCHANGE,3'h0,8'h00,8'h3C,6'h3F,8'h00,8'hC3,10'h03F},
      '{OP_NIBBLE_EXCHANGE_ACC,3'h0,8'hA5,8'h3C,6'h00,8'hC3,8'h3C,10'h000},
      '{OP_SKIP_WHEN_ZERO_MEM,3'h0,8'h00,8'h00,6'h15,8'h00,8'h00,10'h215},
      '{OP_SKIP_WHEN_ZERO_MEM,3'h0,8'h00,8'h01,6'h15,8'h00,8'h01,10'h015},
      '{OP_SKIP_ZERO_COPY_ACC,3'h0,8'h77,8'h00,6'h2A,8'h00,8'h00,10'h22A},
      '{OP_SKIP_BIT_ZERO,3'h3,8'h00,8'hF7,6'h00,8'h00,8'hF7,10'h200},
      '{OP_SKIP_BIT_ZERO,3'h2,8'h00,8'hF7,6'h00,8'h00,8'hF7,10'h000},
      '{OP_EXCLUSIVE_OR_ACC,3'h0,8'hF0,8'h0F,6'h3B,8'hFF,8'h0F,10'h03B},
      '{OP_EXCLUSIVE_OR_MEM,3'h0,8'h5A,8'h5A,6'h3B,8'h5A,8'h00,10'h03F},
      '{OP_EXCLUSIVE_OR_IMM,3'h0,8'h12,8'h13,6'h04,8'h01,8'h13,10'h000},
      '{OP_FAR_ADD_CARRY_ACC,3'h0,8'h7F,8'h00,6'h01,8'h80,8'h00,10'h00A},
      '{OP_FAR_ADD_CARRY_MEM,3'h0,8'hFF,8'h00,6'h21,8'hFF,8'h00,10'h027},
      '{OP_FAR_ADD_ACC,3'h0,8'h88,8'h88,6'h01,8'h10,8'h88,10'h01B},
      '{OP_FAR_ADD_MEM,3'h0,8'h01,8'h02,6'h3F,8'h01,8'h03,10'h020},
      '{OP_FAR_AND_TO_ACC,3'h0,8'hF3,8'h3C,6'h00,8'h30,8'h3C,10'h000},
      '{OP_FAR_AND_TO_MEM,3'h0,8'hF0,8'h0F,6'h3B,8'hF0,8'h00,10'h03F},
      '{OP_FAR_CLEAR,3'h0,8'h00,8'hA5,6'h15,8'h00,8'h00,10'h015},
      '{OP_FAR_CLEAR_BIT,3'h7,8'h00,8'hFF,6'h2A,8'h00,8'h7F,10'h02A},
      '{OP_FAR_INVERT,3'h0,8'h00,8'hFF,6'h00,8'h00,8'h00,10'h004},
      '{OP_FAR_INVERT_TO_ACC,3'h0,8'h11,8'h0F,6'h3F,8'hF0,8'h0F,10'h03B},
      '{OP_FAR_DECIMAL_ADJUST,3'h0,8'hA9,8'h00,6'h02,8'hA9,8'h0F,10'h003},
      '{OP_FAR_DECIMAL_ADJUST,3'h0,8'h45,8'h00,6'h01,8'h45,8'hA5,10'h001},
      '{OP_FAR_DECREMENT_TO_ACC,3'h0,8'h55,8'h01,6'h3B,8'h00,8'h01,10'h03F},
      '{OP_FAR_INCREMENT,3'h0,8'h00,8'hFF,6'h3B,8'h00,8'h00,10'h03F},
      '{OP_FAR_DECREMENT,3'h0,8'h66,8'h00,6'h2E,8'h66,8'hFF,10'h02A},
      '{OP_FAR_INCREMENT_TO_ACC,3'h0,8'h00,8'h7F,6'h3B,8'h80,8'h7F,10'h03B}
   };

   alu_exec_core alu_exec_core_inst (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .skip_o(skip_o));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eer);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
      chk("write error", {31'h0, eer}, {31'h0, er});
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eer);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h0, rd, er);
      chk("read data", exp, rd);
      chk("read error", {31'h0, eer}, {31'h0, er});
   endtask : rdc

   // Probe write lands in the second cycle of execution, refused only by skip forms
   task automatic do_cmd(input op_e op, input logic [2:0] b);
      logic [31:0] rd;
      logic        er;
      wr(OFS_CMD, {21'h0, b, 3'h0, op}, 1'b0);
      wr(OFS_IMM, 32'h0, op inside {OP_SKIP_WHEN_ZERO_MEM, OP_SKIP_ZERO_COPY_ACC, OP_SKIP_BIT_ZERO});
      // A hang here is caught by the watchdog
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      end while (rd[ST_BUSY_BIT] !== 1'b0);
   endtask : do_cmd

   task automatic t_reset_map;
      rdc(OFS_ACC, 32'h0, 1'b0);
      rdc(OFS_STATUS, 32'h0, 1'b0);
      rdc(OFS_TABLE_POINTER_LOW, 32'h0, 1'b0);
      rdc(8'h30, 32'h0, 1'b1);
      wr(8'h40, 32'h1, 1'b1);
   endtask : t_reset_map

   // Each vector uses its own data address, the top byte among them
   task automatic t_vectors;
      logic [7:0] ma;
      for (int i = 0; i < 29; i++) begin
         ma = 8'(8'hFF - i * 37);
         wr(OFS_MADDR, {24'h0, ma}, 1'b0);
         wr(OFS_MDATA, {24'h0, vt[i].mem}, 1'b0);
         wr(OFS_IMM, {24'h0, vt[i].mem}, 1'b0);
         wr(OFS_ACC, {24'h0, vt[i].acc}, 1'b0);
         wr(OFS_STATUS, {26'h0, vt[i].fin}, 1'b0);
         do_cmd(vt[i].op, vt[i].b);
         rdc(OFS_ACC, {24'h0, vt[i].eacc}, 1'b0);
         rdc(OFS_MDATA, {24'h0, vt[i].emem}, 1'b0);
         rdc(OFS_STATUS, {22'h0, vt[i].est}, 1'b0);
         chk("skip_o", {31'h0, vt[i].est[9]}, {31'h0, skip_o});
      end
   endtask : t_vectors

   // High page bit held at zero so last-page reads must ignore it
   task automatic t_table;
      logic [8:0]  pa [4];
      logic [15:0] pw [4];
      op_e         tops [4];
      pa   = '{9'h012, 9'h112, 9'h013, 9'h113};
      pw   = '{16'hBEEF, 16'hCAFE, 16'h1234, 16'h6B5A};
      tops = '{OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST_PAGE, OP_PTR_INC_TABLE_READ, OP_PTR_INC_TABLE_LAST};
      for (int k = 0; k < 4; k++) begin
         wr(OFS_PADDR, {23'h0, pa[k]}, 1'b0);
         wr(OFS_PDATA, {16'h0, pw[k]}, 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         wr(OFS_TABLE_POINTER_HIGH, 32'h0, 1'b0);
         wr(OFS_TABLE_POINTER_LOW, 32'h12, 1'b0);
         wr(OFS_MADDR, 32'hF0, 1'b0);
         wr(OFS_STATUS, 32'h2A, 1'b0);
         do_cmd(tops[k], 3'h0);
         rdc(OFS_MDATA, {24'h0, pw[k][7:0]}, 1'b0);
         rdc(OFS_TABLE_WORD_HIGH_LATCH, {24'h0, pw[k][15:8]}, 1'b0);
         rdc(OFS_TABLE_POINTER_LOW, {24'h0, pa[k][7:0]}, 1'b0);
         rdc(OFS_STATUS, 32'h2A, 1'b0);
      end
   endtask : t_table

   task automatic print_verdict;
      if (fail_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset_map();
      t_vectors();
      t_table();
      print_verdict();
   end
endmodule : mcu_instruction_semantics_s_to_l_test
